// *** logic/csf_sfr_file.sv ***
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_sfr_file (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // SFR bus
  input  wire csf_pkg::csf_sfr_req_t sfr_req,
  output logic                [7:0]  sfr_rdata,
  // Bit access
  input  wire csf_pkg::csf_bit_req_t bit_req,
  output logic                       bit_rdata,
  // Datapath
  input  wire csf_pkg::csf_flag_upd_t flag_upd,
  input  wire logic                  operand_we,
  input  wire logic           [7:0]  operand_wdata,
  input  wire logic                  dptr_we,
  input  wire logic          [15:0]  dptr_wdata,
  input  wire csf_pkg::csf_bank_req_t bank_req,
  output logic                [7:0]  bank_rdata,
  output logic                       bank_hit,
  // Views
  input  wire logic          [15:0]  code_addr,
  output logic               [16:0]  code_phys,
  output logic               [15:0]  dptr_active,
  output logic                [7:0]  operand_out,
  output logic                [7:0]  second_out,
  output logic                [7:0]  flags_out,
  output logic                [7:0]  arbiter_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] p0_reg, p0_next, p1_reg, p1_next;
  logic        choice_reg, choice_next;
  logic [1:0]  win_reg, win_next;
  logic        unif_reg, unif_next, cdis_reg, cdis_next;
  logic [7:0]  flags_reg, flags_next;
  logic [7:0]  op_reg, op_next, sec_reg, sec_next;
  logic [7:0]  rd_next;
  logic [16:0] phys_next;
  logic        bit_next;

  function automatic logic [7:0] bit_set(input logic [7:0] v, input logic [2:0] s,
                                         input logic b);
    logic [7:0] r;
    r    = v;
    r[s] = b;
    return r;
  endfunction

  function automatic logic hit(input csf_pkg::csf_sfr_req_t q, input logic [7:0] a);
    return q.wr && (q.addr == a);
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire w_p0l = hit(sfr_req, `CSF_ADR_P0_LOW);
  wire w_p0h = hit(sfr_req, `CSF_ADR_P0_HIGH);
  wire w_p1l = hit(sfr_req, `CSF_ADR_P1_LOW);
  wire w_p1h = hit(sfr_req, `CSF_ADR_P1_HIGH);
  wire w_ch  = hit(sfr_req, `CSF_ADR_CHOICE);
  wire w_win = hit(sfr_req, `CSF_ADR_WINDOW);
  wire w_arb = hit(sfr_req, `CSF_ADR_ARBITER);
  wire w_fl  = hit(sfr_req, `CSF_ADR_FLAGS);
  wire w_op  = hit(sfr_req, `CSF_ADR_OPERAND);
  wire w_sec = hit(sfr_req, `CSF_ADR_SECOND);
  wire b_fl  = bit_req.wr && (bit_req.addr == `CSF_ADR_FLAGS);
  wire b_op  = bit_req.wr && (bit_req.addr == `CSF_ADR_OPERAND);
  wire b_sec = bit_req.wr && (bit_req.addr == `CSF_ADR_SECOND);

  // Datapath pointer write goes to the selected pointer
  assign p0_next = (dptr_we && !choice_reg) ? dptr_wdata :
                   {w_p0h ? sfr_req.wdata : p0_reg[15:8],
                    w_p0l ? sfr_req.wdata : p0_reg[7:0]};
  assign p1_next = (dptr_we && choice_reg) ? dptr_wdata :
                   {w_p1h ? sfr_req.wdata : p1_reg[15:8],
                    w_p1l ? sfr_req.wdata : p1_reg[7:0]};
  // Only bit 0 is stored, upper bits ignored
  assign choice_next = w_ch ? sfr_req.wdata[0] : choice_reg;
  // One copy of the window, two addresses write it
  assign win_next = w_win ? sfr_req.wdata[1:0] :
                    w_arb ? sfr_req.wdata[`CSF_ARB_WIN_LO +: 2] :
                    win_reg;
  assign unif_next = w_arb ? sfr_req.wdata[`CSF_ARB_UNIF] : unif_reg;
  assign cdis_next = w_arb ? sfr_req.wdata[`CSF_ARB_CDIS] : cdis_reg;

  assign op_next  = operand_we ? operand_wdata :
                    w_op ? sfr_req.wdata :
                    b_op ? bit_set(op_reg, bit_req.bitsel, bit_req.value) : op_reg;
  assign sec_next = w_sec ? sfr_req.wdata :
                    b_sec ? bit_set(sec_reg, bit_req.bitsel, bit_req.value) :
                    sec_reg;

  // Flags: software write beats bit write, then arithmetic update wins on CY, AC and OV
  logic [7:0] fl_sw;
  assign fl_sw = w_fl ? sfr_req.wdata :
                 b_fl ? bit_set(flags_reg, bit_req.bitsel, bit_req.value) :
                 flags_reg;
  always_comb begin
    flags_next = fl_sw;
    if (flag_upd.upd) begin
      flags_next[`CSF_BIT_CY] = flag_upd.cy;
      flags_next[`CSF_BIT_AC] = flag_upd.ac;
      flags_next[`CSF_BIT_OV] = flag_upd.ov;
    end
    // Parity tracks the operand as it will be, never stored stale
    flags_next[`CSF_BIT_PAR] = ^op_next;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    unique case (sfr_req.addr)
      `CSF_ADR_P0_LOW:  rd_next = p0_reg[7:0];
      `CSF_ADR_P0_HIGH: rd_next = p0_reg[15:8];
      `CSF_ADR_P1_LOW:  rd_next = p1_reg[7:0];
      `CSF_ADR_P1_HIGH: rd_next = p1_reg[15:8];
      `CSF_ADR_CHOICE:  rd_next = {7'h00, choice_reg};
      `CSF_ADR_WINDOW:  rd_next = {6'h00, win_reg};
      `CSF_ADR_ARBITER: rd_next = {1'b0, unif_reg, win_reg, 2'h0, cdis_reg, 1'b1};
      `CSF_ADR_FLAGS:   rd_next = flags_reg;
      `CSF_ADR_OPERAND: rd_next = op_reg;
      `CSF_ADR_SECOND:  rd_next = sec_reg;
      default:          rd_next = `CSF_ZERO8;
    endcase
  end
  assign bit_next = (bit_req.addr == `CSF_ADR_FLAGS)   ? flags_reg[bit_req.bitsel] :
                    (bit_req.addr == `CSF_ADR_OPERAND) ? op_reg[bit_req.bitsel] :
                    (bit_req.addr == `CSF_ADR_SECOND)  ? sec_reg[bit_req.bitsel] :
                    1'b0;

  // Upper half of code space goes through the window
  assign phys_next = code_addr[15] ? {win_reg, code_addr[14:0]} :
                                     {2'h0, code_addr[14:0]};

  // ----------------------------------------
  // Working banks
  // ----------------------------------------
  wire in_data = !bank_req.xdata && (bank_req.addr[15:5] == 11'h000);
  wire in_x    = bank_req.xdata && (bank_req.addr >= `CSF_XBANK_BASE) &&
                 (bank_req.addr <= `CSF_XBANK_TOP);
  wire bank_sel = in_data || in_x;
  // A register number 0..7 maps into the bank chosen by the flags
  wire       bank_rn = bank_req.addr[15];
  wire [4:0] bank_a  = bank_rn ? {flags_reg[`CSF_BIT_RS_LO +: 2], bank_req.addr[2:0]} :
                                 bank_req.addr[4:0];
  wire bank_ok = bank_sel || (bank_rn && !bank_req.xdata);
  logic hit_reg;

  csf_bank_mem u_bank (
    .clk   (clk),
    .we    (bank_req.wr && bank_ok),
    .addr  (bank_a),
    .wdata (bank_req.wdata),
    .rdata (bank_rdata)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p0_reg     <= 16'h0000;
      p1_reg     <= 16'h0000;
      choice_reg <= 1'b0;
      win_reg    <= `CSF_WIN_RESET;
      unif_reg   <= 1'b0;
      cdis_reg   <= 1'b0;
      flags_reg  <= `CSF_ZERO8;
      op_reg     <= `CSF_ZERO8;
      sec_reg    <= `CSF_ZERO8;
      sfr_rdata  <= `CSF_ZERO8;
      bit_rdata  <= 1'b0;
      code_phys  <= 17'h00000;
      hit_reg    <= 1'b0;
    end else begin
      p0_reg     <= p0_next;
      p1_reg     <= p1_next;
      choice_reg <= choice_next;
      win_reg    <= win_next;
      unif_reg   <= unif_next;
      cdis_reg   <= cdis_next;
      flags_reg  <= flags_next;
      op_reg     <= op_next;
      sec_reg    <= sec_next;
      sfr_rdata  <= rd_next;
      bit_rdata  <= bit_next;
      code_phys  <= phys_next;
      hit_reg    <= bank_req.rd && bank_ok;
    end
  end
  assign bank_hit    = hit_reg;
  assign dptr_active = choice_reg ? p1_reg : p0_reg;
  assign operand_out = op_reg;
  assign second_out  = sec_reg;
  assign flags_out   = flags_reg;
  assign arbiter_out = {1'b0, unif_reg, win_reg, 2'h0, cdis_reg, 1'b1};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_parity_tracks: assert property (@(posedge clk) disable iff (sys_rst)
    flags_reg[`CSF_BIT_PAR] == ^op_reg) else $error("parity flag wrong");
  a_window_alias: assert property (@(posedge clk) disable iff (sys_rst)
    w_arb && !w_win |=> win_reg == $past(sfr_req.wdata[5:4])) else $error("alias lost");
  a_window_reset: assert property (@(posedge clk)
    sys_rst |=> win_reg == 2'h1) else $error("window reset wrong");
  a_window_map: assert property (@(posedge clk) disable iff (sys_rst)
    code_addr[15] |=> code_phys[16:15] == $past(win_reg))
    else $error("window map wrong");
  a_carry_update: assert property (@(posedge clk) disable iff (sys_rst)
    flag_upd.upd |=> flags_reg[7] == $past(flag_upd.cy)) else $error("carry not updated");
  a_nibble_update: assert property (@(posedge clk) disable iff (sys_rst)
    flag_upd.upd |=> flags_reg[6] == $past(flag_upd.ac)) else $error("nibble carry wrong");
  a_range_update: assert property (@(posedge clk) disable iff (sys_rst)
    flag_upd.upd |=> flags_reg[2] == $past(flag_upd.ov)) else $error("overflow wrong");
  a_choice_sel: assert property (@(posedge clk) disable iff (sys_rst)
    dptr_active == (choice_reg ? p1_reg : p0_reg)) else $error("pointer select wrong");
  a_choice_zero: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.addr == `CSF_ADR_CHOICE |=> sfr_rdata[7:1] == 7'h00)
    else $error("unused choice bits set");
  a_user_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !w_fl && !b_fl |=> flags_reg[5] == $past(flags_reg[5])) else $error("user flag moved");
endmodule

// *** logic/csf_map.svh ***
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSF_ADR_P0_LOW   8'h82
`define CSF_ADR_P0_HIGH  8'h83
`define CSF_ADR_P1_LOW   8'h84
`define CSF_ADR_P1_HIGH  8'h85
`define CSF_ADR_CHOICE   8'h92
`define CSF_ADR_WINDOW   8'h9F
`define CSF_ADR_ARBITER  8'hC7
`define CSF_ADR_FLAGS    8'hD0
`define CSF_ADR_OPERAND  8'hE0
`define CSF_ADR_SECOND   8'hF0

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CSF_WIN_RESET    2'h1
`define CSF_ARB_WIN_LO   4
`define CSF_ARB_UNIF     6
`define CSF_ARB_CDIS     1
`define CSF_BIT_CY       7
`define CSF_BIT_AC       6
`define CSF_BIT_UA       5
`define CSF_BIT_RS_LO    3
`define CSF_BIT_OV       2
`define CSF_BIT_UB       1
`define CSF_BIT_PAR      0
`define CSF_ZERO8        8'h00
`define CSF_BANK_BASE    8'h00
`define CSF_BANK_TOP     8'h1F
`define CSF_XBANK_BASE   16'hFF00
`define CSF_XBANK_TOP    16'hFF1F
`define CSF_WIN_LOW      16'h8000
`endif

// *** logic/csf_pkg.sv ***
package csf_pkg;
  // SFR bus access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csf_sfr_req_t;
  // Bit access on bit-addressable registers
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic       value;
  } csf_bit_req_t;
  // Flag update from datapath arithmetic
  typedef struct packed {
    logic upd;
    logic cy;
    logic ac;
    logic ov;
  } csf_flag_upd_t;
  // Working register access (DATA or XDATA alias)
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        xdata;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } csf_bank_req_t;
endpackage

// *** logic/csf_bank_mem.sv ***
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_bank_mem (
  // Clock
  input  wire logic       clk,
  // Port
  input  wire logic       we,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// *** tb/csf_dpath_model.sv ***
`timescale 1ns/1ps
module csf_dpath_model (
  // Command
  input  wire logic                   go,
  input  wire logic                   sub,
  // Register views
  input  wire logic             [7:0] a,
  input  wire logic             [7:0] b,
  // Writes into the file
  output csf_pkg::csf_flag_upd_t      flag_upd,
  output logic                        operand_we,
  output logic                  [7:0] operand_wdata
);
  logic [8:0] full;
  logic [4:0] low;
  // ----------------------------------------
  // Behavioural add and subtract, no carry in
  // ----------------------------------------
  assign full = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
  assign low  = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
  // Borrow shows as the wrapped bit above each field
  assign flag_upd      = '{upd: go, cy: full[8], ac: low[4], ov: full[8]};
  assign operand_we    = go;
  assign operand_wdata = full[7:0];
endmodule

// *** tb/csf_sfr_file_bench.sv ***
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_sfr_file_bench;
  logic                   clk;
  logic                   sys_rst;
  csf_pkg::csf_sfr_req_t  sfr_req;
  csf_pkg::csf_bit_req_t  bit_req;
  csf_pkg::csf_bank_req_t bank_req;
  csf_pkg::csf_flag_upd_t flag_upd;
  logic [7:0]  sfr_rdata, bank_rdata, operand_out, second_out, flags_out, arbiter_out;
  logic [7:0]  operand_wdata;
  logic        bit_rdata, bank_hit, operand_we, dptr_we, go, sub;
  logic [15:0] dptr_wdata, code_addr, dptr_active;
  logic [16:0] code_phys;
  int          bad_count, cmp_count;
  logic [7:0]  rv;

  csf_sfr_file csf_sfr_file_inst (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .bit_req(bit_req), .bit_rdata(bit_rdata), .flag_upd(flag_upd),
    .operand_we(operand_we), .operand_wdata(operand_wdata), .dptr_we(dptr_we),
    .dptr_wdata(dptr_wdata), .bank_req(bank_req), .bank_rdata(bank_rdata),
    .bank_hit(bank_hit), .code_addr(code_addr), .code_phys(code_phys),
    .dptr_active(dptr_active), .operand_out(operand_out), .second_out(second_out),
    .flags_out(flags_out), .arbiter_out(arbiter_out));

  csf_dpath_model csf_dpath_model_inst (.go(go), .sub(sub), .a(operand_out), .b(second_out),
    .flag_upd(flag_upd), .operand_we(operand_we), .operand_wdata(operand_wdata));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) sfr_req.wr <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) sfr_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk) sfr_req.rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic bank_op(input logic w, input logic x, input logic [15:0] a,
                         input logic [7:0] d);
    @(posedge clk) bank_req <= '{rd: ~w, wr: w, xdata: x, addr: a, wdata: d};
    @(posedge clk) begin
      bank_req.wr <= 1'b0;
      bank_req.rd <= 1'b0;
    end
    #1;
  endtask

  task automatic arith(input logic s);
    @(posedge clk) begin go <= 1'b1; sub <= s; end
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin : main
    static logic [7:0] adr [10] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h9F, 8'hC7, 8'hD0,
                             8'hE0, 8'hF0};
    static logic [7:0] rst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h11, 8'h00,
                             8'h00, 8'h00};
    static logic [16:0] base [4] = '{17'h00000, 17'h08000, 17'h10000, 17'h18000};
    bad_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    sfr_req = '0;
    bit_req = '0;
    bank_req = '0;
    dptr_we = 1'b0;
    dptr_wdata = 16'h0000;
    go = 1'b0;
    sub = 1'b0;
    code_addr = 16'hC234;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      sfr_rd(adr[i], rv);
      chk(rv, rst[i]);
    end
    sfr_rd(8'h90, rv);
    chk(rv, 8'h00);
    // Window codes, written straight and seen through the arbiter view
    for (int i = 0; i < 4; i++) begin
      sfr_wr(`CSF_ADR_WINDOW, {6'h3F, i[1:0]});
      repeat (2) @(posedge clk);
      #1 chk(code_phys, base[i] + 17'h04234);
      chk(arbiter_out[5:4], i[1:0]);
      sfr_rd(`CSF_ADR_WINDOW, rv);
      chk(rv, {6'h00, i[1:0]});
    end
    // Lower half of code space never goes through the window, then a window write through the arbiter alias
    @(posedge clk) code_addr <= 16'h1234;
    repeat (2) @(posedge clk);
    #1 chk(code_phys, 17'h01234);
    sfr_wr(`CSF_ADR_ARBITER, 8'h21);
    sfr_rd(`CSF_ADR_WINDOW, rv);
    chk(rv, 8'h02);
    // Pointer bytes and selection
    sfr_wr(`CSF_ADR_P0_LOW, 8'h34);
    sfr_wr(`CSF_ADR_P0_HIGH, 8'h12);
    sfr_wr(`CSF_ADR_CHOICE, 8'hFF);
    sfr_rd(`CSF_ADR_CHOICE, rv);
    chk(rv, 8'h01);
    @(posedge clk) begin dptr_we <= 1'b1; dptr_wdata <= 16'hBEEF; end
    @(posedge clk) dptr_we <= 1'b0;
    sfr_rd(`CSF_ADR_P1_LOW, rv);
    chk(rv, 8'hEF);
    sfr_rd(`CSF_ADR_P1_HIGH, rv);
    chk(rv, 8'hBE);
    chk(dptr_active, 16'hBEEF);
    sfr_wr(`CSF_ADR_CHOICE, 8'h00);
    #1 chk(dptr_active, 16'h1234);
    // Working banks through the group select, direct and alias views
    for (int g = 0; g < 4; g++) begin
      sfr_wr(`CSF_ADR_FLAGS, {3'h0, g[1:0], 3'h0});
      bank_op(1'b1, 1'b0, 16'h8003, 8'hA0 + 8'(g));
      bank_op(1'b0, 1'b0, 16'(g * 8 + 3), 8'h00);
      chk(bank_rdata, 8'hA0 + 8'(g));
      chk(bank_hit, 1'b1);
      bank_op(1'b0, 1'b1, 16'hFF00 + 16'(g * 8 + 3), 8'h00);
      chk(bank_rdata, 8'hA0 + 8'(g));
    end
    // Just past the alias range is no working register
    bank_op(1'b0, 1'b1, 16'hFF20, 8'h00);
    chk(bank_hit, 1'b0);
    // User bits, bit access, parity and arithmetic flags
    sfr_wr(`CSF_ADR_FLAGS, 8'h22);
    sfr_rd(`CSF_ADR_FLAGS, rv);
    chk(rv, 8'h22);
    @(posedge clk) bit_req <= '{wr: 1'b1, addr: 8'hD0, bitsel: 3'h7, value: 1'b1};
    @(posedge clk) bit_req.wr <= 1'b0;
    #1 chk(flags_out, 8'hA2);
    sfr_wr(`CSF_ADR_FLAGS, 8'h00);
    sfr_wr(`CSF_ADR_OPERAND, 8'h07);
    #1 chk(flags_out[0], 1'b1);
    sfr_wr(`CSF_ADR_OPERAND, 8'h88);
    sfr_wr(`CSF_ADR_SECOND, 8'h88);
    arith(1'b0);
    chk(operand_out, 8'h10);
    chk(flags_out, 8'hC5);
    sfr_wr(`CSF_ADR_SECOND, 8'h01);
    arith(1'b1);
    chk(operand_out, 8'h0F);
    chk(flags_out, 8'h40);
    end_sim();
  end
endmodule
